// ==== verification/sfm_emcy_listener.sv ====
/* network side listener: counts emergency entries per fault channel.
   assumes entries arrive as one-cycle pulses on clk */
module sfm_emcy_listener
    import sfm_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic [2:0]      emcy_entry,
    output logic      [2:0][7:0] cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    // one count per entry added to the error list
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= '0;
        end else begin
            for (int i = 0; i < SFM_FAULTS; i++) begin
                cnt[i] <= cnt[i] + 8'(emcy_entry[i]);
            end
        end
    end
endmodule

// ==== verification/sfm_supply_fault_monitor_sva.sv ====
/* checker for the supply fault monitor: object handshake, limit faults,
   fault release and entry pulses.
   assumes it is bound to the monitor and sees only its ports */
module sfm_supply_fault_monitor_sva
    import sfm_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [15:0] supply_meas,
    input wire logic        output_fault_in,
    input wire logic        rpdo_timeout_in,
    input wire logic        obj_wr,
    input wire logic        obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [7:0]  obj_sub,
    input wire logic [15:0] obj_wdata,
    input wire logic [15:0] obj_rdata,
    input wire logic        obj_ack,
    input wire logic        obj_err,
    input wire logic        over_fault,
    input wire logic        under_fault,
    input wire logic [2:0]  fault_active,
    input wire logic [2:0]  emcy_entry
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // object port answers exactly one cycle after a strobe
    a_ack_one_cycle: assert property (obj_ack == $past(obj_wr || obj_rd))
        else $error("ack not one cycle after strobe");
    a_err_with_ack: assert property (obj_err |-> obj_ack)
        else $error("err without ack");
    a_rdata_holds: assert property (!$past(obj_rd && !obj_wr) |-> $stable(obj_rdata))
        else $error("read data moved without a read");
    // limits can never be wider than their ranges
    a_over_sets: assert property (supply_meas > SFM_UPPER_MAX |=> over_fault)
        else $error("over fault missing");
    a_under_sets: assert property (supply_meas < SFM_LOWER_MIN |=> under_fault)
        else $error("under fault missing");
    // supply and output entries only while the condition stands, output then active; timeout entries last one cycle
    a_supply_entry: assert property (emcy_entry[SFM_CH_SUPPLY] |-> over_fault || under_fault)
        else $error("supply entry without fault");
    a_output_entry: assert property (emcy_entry[SFM_CH_OUTPUT] |-> output_fault_in)
        else $error("output entry without fault");
    a_entry_then_active: assert property (emcy_entry[SFM_CH_OUTPUT] |=> fault_active[SFM_CH_OUTPUT])
        else $error("entry not followed by active");
    a_rpdo_pulse: assert property (emcy_entry[SFM_CH_RPDO] |=> !emcy_entry[SFM_CH_RPDO])
        else $error("timeout entry longer than a cycle");
    // a dropped condition takes the fault down
    a_output_drop: assert property (!output_fault_in [*2] |-> !fault_active[SFM_CH_OUTPUT])
        else $error("output fault stays active");
    a_rpdo_drop: assert property (!rpdo_timeout_in [*2] |-> !fault_active[SFM_CH_RPDO])
        else $error("timeout fault stays active");
endmodule

bind sfm_supply_fault_monitor sfm_supply_fault_monitor_sva i_sfm_supply_fault_monitor_sva (
    .clk, .sys_rst, .supply_meas, .output_fault_in, .rpdo_timeout_in, .obj_wr, .obj_rd, .obj_index,
    .obj_sub, .obj_wdata, .obj_rdata, .obj_ack, .obj_err, .over_fault, .under_fault, .fault_active,
    .emcy_entry
);

// ==== verification/tb_sfm_supply_fault_monitor.sv ====
/* testbench for the supply fault monitor: object table walk, then
   hysteresis, reaction delay, enable and reset cases.
   assumes a 40 MHz clock and a four-cycle millisecond tick */
module tb_sfm_supply_fault_monitor
    import sfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic        w;
        logic [7:0]  ix;
        logic [7:0]  sb;
        logic [15:0] d;
        logic [15:0] q;
        logic        e;
    } sfm_row_t;
    logic            clk;
    logic            sys_rst = 1'h1;
    logic [15:0]     supply_meas = 16'h00C8;
    logic            output_fault_in = 1'h0;
    logic            rpdo_timeout_in = 1'h0;
    logic            obj_wr = 1'h0;
    logic            obj_rd = 1'h0;
    logic [15:0]     obj_index = 16'h0000;
    logic [7:0]      obj_sub = 8'h00;
    logic [15:0]     obj_wdata = 16'h0000;
    logic [15:0]     obj_rdata;
    logic            obj_ack;
    logic            obj_err;
    logic            over_fault;
    logic            under_fault;
    logic [2:0]      fault_active;
    logic [2:0]      emcy_entry;
    logic [2:0][7:0] cnt;
    logic            ack_seen;
    logic            err_seen;
    logic [15:0]     rdata_seen;
    int              n_errors = 0;
    int              comparisons = 0;
    // reads of reset values, refused writes, accepted writes
    localparam sfm_row_t ROWS [18] = '{
        '{1'h0, 8'h02, 8'h00, 16'h0000, 16'h012C, 1'h0}, '{1'h0, 8'h01, 8'h00, 16'h0000, 16'h005A, 1'h0},
        '{1'h0, 8'h10, 8'h00, 16'h0000, 16'h0003, 1'h0}, '{1'h0, 8'h10, 8'h01, 16'h0000, 16'h0001, 1'h0},
        '{1'h0, 8'h10, 8'h03, 16'h0000, 16'h0001, 1'h0}, '{1'h0, 8'h11, 8'h01, 16'h0000, 16'h000F, 1'h0},
        '{1'h0, 8'h11, 8'h02, 16'h0000, 16'h0000, 1'h0}, '{1'h0, 8'h12, 8'h01, 16'h0000, 16'h03E8, 1'h0},
        '{1'h0, 8'h12, 8'h03, 16'h0000, 16'h03E8, 1'h0}, '{1'h0, 8'h03, 8'h00, 16'h0000, 16'h0000, 1'h1},
        '{1'h1, 8'h02, 8'h00, 16'h0259, 16'h0000, 1'h1}, '{1'h1, 8'h02, 8'h00, 16'h0258, 16'h0000, 1'h0},
        '{1'h0, 8'h02, 8'h00, 16'h0000, 16'h0258, 1'h0}, '{1'h1, 8'h11, 8'h01, 16'h0033, 16'h0000, 1'h1},
        '{1'h1, 8'h11, 8'h02, 16'h0001, 16'h0000, 1'h1}, '{1'h1, 8'h10, 8'h01, 16'h0002, 16'h0000, 1'h1},
        '{1'h1, 8'h12, 8'h01, 16'hEA61, 16'h0000, 1'h1}, '{1'h1, 8'h12, 8'h01, 16'h0000, 16'h0000, 1'h0}};

    sfm_supply_fault_monitor #(.TICK_CYCLES(4)) i_sfm_supply_fault_monitor (
        .clk, .sys_rst, .supply_meas, .output_fault_in, .rpdo_timeout_in, .obj_wr, .obj_rd, .obj_index,
        .obj_sub, .obj_wdata, .obj_rdata, .obj_ack, .obj_err, .over_fault, .under_fault, .fault_active,
        .emcy_entry);
    sfm_emcy_listener i_sfm_emcy_listener (.clk, .sys_rst, .emcy_entry, .cnt);

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one strobe cycle; the one-cycle answer is caught at the next falling edge
    task automatic acc(input logic w, input logic [7:0] ix, input logic [7:0] sb, input logic [15:0] d);
        obj_wr = w;
        obj_rd = !w;
        obj_index = {8'h26, ix};
        obj_sub = sb;
        obj_wdata = d;
        @(negedge clk);
        ack_seen = obj_ack;
        err_seen = obj_err;
        rdata_seen = obj_rdata;
        obj_wr = 1'h0;
        obj_rd = 1'h0;
        @(negedge clk);
    endtask
    task automatic sup(input logic [15:0] m, input logic ov, input logic un);
        supply_meas = m;
        repeat (2) @(negedge clk);
        chk("over_fault", {15'h0000, ov}, {15'h0000, over_fault});
        chk("under_fault", {15'h0000, un}, {15'h0000, under_fault});
    endtask
    task automatic hold_out(input int n, input logic a);
        output_fault_in = 1'h1;
        repeat (n) @(negedge clk);
        chk("out_active", {15'h0000, a}, {15'h0000, fault_active[1]});
        output_fault_in = 1'h0;
        repeat (2) @(negedge clk);
        chk("out_dropped", 16'h0000, {15'h0000, fault_active[1]});
    endtask

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // watchdog at about two and a half times the expected run
    initial begin
        #250us;
        n_errors++;
        results();
    end
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'h0;
        foreach (ROWS[i]) begin
            acc(ROWS[i].w, ROWS[i].ix, ROWS[i].sb, ROWS[i].d);
            chk("ack", 16'h0001, {15'h0000, ack_seen});
            chk("err", {15'h0000, ROWS[i].e}, {15'h0000, err_seen});
            if (!ROWS[i].w) chk("rdata", ROWS[i].q, rdata_seen);
        end
        // upper 600, lower 90, hysteresis 15, supply delay 0
        sup(16'h0259, 1'h1, 1'h0);
        chk("supply_active", 16'h0001, {15'h0000, fault_active[0]});
        sup(16'h024A, 1'h1, 1'h0);
        sup(16'h0248, 1'h0, 1'h0);
        sup(16'h0059, 1'h0, 1'h1);
        sup(16'h003B, 1'h0, 1'h1);
        sup(16'h0069, 1'h0, 1'h1);
        sup(16'h006A, 1'h0, 1'h0);
        chk("supply_idle", 16'h0000, {15'h0000, fault_active[0]});
        chk("supply_entries", 16'h0002, 16'(cnt[0]));
        // output delay 2 ms: short episode, full episode, then disabled
        acc(1'h1, 8'h12, 8'h02, 16'h0002);
        hold_out(3, 1'h0);
        chk("out_entries", 16'h0000, 16'(cnt[1]));
        hold_out(12, 1'h1);
        chk("out_entries", 16'h0001, 16'(cnt[1]));
        acc(1'h1, 8'h10, 8'h02, 16'h0000);
        hold_out(12, 1'h1);
        chk("out_entries", 16'h0001, 16'(cnt[1]));
        // timeout channel keeps the 1000 ms default
        rpdo_timeout_in = 1'h1;
        repeat (3980) @(negedge clk);
        chk("rpdo_early", 16'h0000, {15'h0000, fault_active[2]});
        repeat (40) @(negedge clk);
        chk("rpdo_active", 16'h0001, {15'h0000, fault_active[2]});
        chk("rpdo_entries", 16'h0001, 16'(cnt[2]));
        rpdo_timeout_in = 1'h0;
        // second reset restores the upper limit
        sys_rst = 1'h1;
        @(negedge clk);
        sys_rst = 1'h0;
        acc(1'h0, 8'h02, 8'h00, 16'h0000);
        chk("upper_after_reset", 16'h012C, obj_rdata);
        results();
    end
endmodule

// ==== verilog/sfm_fault_timer.sv ====
/*
 * One fault channel: qualifies a raw fault condition with the reaction
 * delay counted in millisecond ticks.
 * Assumes tick is a one-cycle pulse every millisecond.
 */
module sfm_fault_timer
    import sfm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        tick,
    input  wire logic        cond,
    input  wire logic [15:0] delay_ms,
    output logic             active,
    output logic             recognised
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic        next_active;

    // count whole ms while the condition holds, restart when it drops
    always_comb begin
        next_count  = count;
        next_active = active;
        if (!cond) begin
            next_count  = SFM_ZERO16; // R12
            next_active = 1'b0;
        end else if (!active) begin
            if (count >= delay_ms) begin
                next_active = 1'b1; // R9
            end else if (tick) begin
                next_count = count + 16'h0001;
            end
        end
    end

    // state registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count  <= 16'h0000;
            active <= 1'b0;
        end else begin
            count  <= next_count;
            active <= next_active;
        end
    end

    assign recognised = cond & (count >= delay_ms) & !active; // one-cycle entry pulse
endmodule

// ==== verilog/sfm_pkg.sv ====
/*
 * Constants for the supply fault monitor: object indices, sub-indices,
 * limits, reset values and the millisecond tick derivation.
 * Assumes a single 40 MHz system clock.
 */
package sfm_pkg;
    // object indices of the configuration dictionary
    localparam logic [15:0] SFM_IDX_LOWER_LIMIT = 16'h2601;
    localparam logic [15:0] SFM_IDX_UPPER_LIMIT = 16'h2602;
    localparam logic [15:0] SFM_IDX_ENABLES     = 16'h2610;
    localparam logic [15:0] SFM_IDX_HYSTERESIS  = 16'h2611;
    localparam logic [15:0] SFM_IDX_DELAY       = 16'h2612;
    // sub-index numbers
    localparam logic [7:0]  SFM_SUB_COUNT  = 8'h00;
    localparam logic [7:0]  SFM_SUB_SUPPLY = 8'h01;
    localparam logic [7:0]  SFM_SUB_OUTPUT = 8'h02;
    localparam logic [7:0]  SFM_SUB_RPDO   = 8'h03;
    localparam logic [15:0] SFM_SUB_TOTAL  = 16'h0003;
    // fault channel numbers
    localparam int SFM_FAULTS   = 3;
    localparam int SFM_CH_SUPPLY = 0;
    localparam int SFM_CH_OUTPUT = 1;
    localparam int SFM_CH_RPDO   = 2;
    // supply limits in 0.1 V counts
    localparam logic [15:0] SFM_UPPER_MAX   = 16'h0258; // 600
    localparam logic [15:0] SFM_UPPER_RESET = 16'h012C; // 300
    localparam logic [15:0] SFM_LOWER_MIN   = 16'h003C; // 60
    localparam logic [15:0] SFM_LOWER_RESET = 16'h005A; // 90
    localparam logic [15:0] SFM_HYST_MIN    = 16'h0005; // 5
    localparam logic [15:0] SFM_HYST_MAX    = 16'h0032; // 50
    localparam logic [15:0] SFM_HYST_RESET  = 16'h000F; // 15
    localparam logic [15:0] SFM_ZERO16      = 16'h0000;
    // reaction delay in ms
    localparam logic [15:0] SFM_DELAY_MAX   = 16'hEA60; // 60000
    localparam logic [15:0] SFM_DELAY_RESET = 16'h03E8; // 1000
    localparam logic        SFM_ENABLE_RESET = 1'b1;
    // millisecond tick from the 40 MHz clock
    localparam int SFM_CLK_HZ    = 40000000;
    localparam int SFM_TICK_MS   = 1;
    localparam int SFM_TICK_CYCLES = SFM_CLK_HZ / 1000 * SFM_TICK_MS;
endpackage

// ==== verilog/sfm_supply_fault_monitor.sv ====
/*
 * Supply fault monitor: holds the fault configuration objects, decides the
 * supply over/under-voltage fault with hysteresis, qualifies all three
 * faults with reaction delays and emits emergency entry pulses.
 * Assumes object access arrives as single-cycle read/write strobes with
 * index and sub-index, and that the output and timeout faults are
 * detected elsewhere and given as levels.
 */

// Functional notes
// R1 - over upper limit raises positive overload
// R2 - upper limit counts in 0.1 V
// R3 - upper limit from lower to 600, reset 300
// R4 - three enables; disabled fault makes no entry
// R5 - enables boolean, reset enabled
// R6 - supply fault clears only past hysteresis
// R7 - hysteresis 5 to 50, reset 15
// R8 - other two hysteresis entries read zero
// R9 - recognise after continuous reaction delay
// R10 - delay 0 to 60000 ms, reset 1000
// R11 - under lower limit raises negative overload
// R12 - dropped condition restarts delay timer
module sfm_supply_fault_monitor
    import sfm_pkg::*;
#(
    parameter int TICK_CYCLES = SFM_TICK_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] supply_meas,
    input  wire logic        output_fault_in,
    input  wire logic        rpdo_timeout_in,
    input  wire logic        obj_wr,
    input  wire logic        obj_rd,
    input  wire logic [15:0] obj_index,
    input  wire logic [7:0]  obj_sub,
    input  wire logic [15:0] obj_wdata,
    output logic [15:0]      obj_rdata,
    output logic             obj_ack,
    output logic             obj_err,
    output logic             over_fault,
    output logic             under_fault,
    output logic [2:0]       fault_active,
    output logic [2:0]       emcy_entry
);
    logic [15:0] upper_limit, next_upper_limit;
    logic [15:0] lower_limit, next_lower_limit;
    logic [15:0] hysteresis, next_hysteresis;
    logic [2:0]  enables, next_enables;
    logic [15:0] delay [SFM_FAULTS];
    logic [15:0] next_delay [SFM_FAULTS];
    logic [15:0] next_rdata;
    logic        next_ack, next_err;
    logic        next_over, next_under;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic        tick;
    logic [2:0]  cond, recog, act;
    logic [16:0] upper_clear, lower_clear;
    logic        sub_ok;

    // millisecond enable divider
    always_comb begin
        tick = (tick_cnt == 32'(TICK_CYCLES - 1));
        next_tick_cnt = tick ? 32'h00000000 : tick_cnt + 32'h00000001;
    end

    // object dictionary write, with range checks and read mux
    always_comb begin
        next_upper_limit = upper_limit;
        next_lower_limit = lower_limit;
        next_hysteresis  = hysteresis;
        next_enables     = enables;
        next_delay       = delay;
        next_rdata       = obj_rdata;
        next_ack         = 1'b0;
        next_err         = 1'b0;
        sub_ok = (obj_sub >= SFM_SUB_SUPPLY) && (obj_sub <= SFM_SUB_RPDO);
        if (obj_wr) begin
            next_ack = 1'b1;
            case (obj_index)
                SFM_IDX_UPPER_LIMIT: begin
                    if (obj_sub == SFM_SUB_COUNT && obj_wdata >= lower_limit
                        && obj_wdata <= SFM_UPPER_MAX) begin
                        next_upper_limit = obj_wdata; // R3
                    end else begin
                        next_err = 1'b1;
                    end
                end
                SFM_IDX_LOWER_LIMIT: begin
                    if (obj_sub == SFM_SUB_COUNT && obj_wdata >= SFM_LOWER_MIN
                        && obj_wdata <= upper_limit) begin
                        next_lower_limit = obj_wdata; // R11
                    end else begin
                        next_err = 1'b1;
                    end
                end
                SFM_IDX_ENABLES: begin
                    if (sub_ok && obj_wdata <= 16'h0001) begin
                        next_enables[obj_sub[1:0] - 2'h1] = obj_wdata[0]; // R5
                    end else begin
                        next_err = 1'b1;
                    end
                end
                SFM_IDX_HYSTERESIS: begin
                    if (obj_sub == SFM_SUB_SUPPLY && obj_wdata >= SFM_HYST_MIN
                        && obj_wdata <= SFM_HYST_MAX) begin
                        next_hysteresis = obj_wdata; // R7
                    end else begin
                        next_err = 1'b1; // R8
                    end
                end
                SFM_IDX_DELAY: begin
                    if (sub_ok && obj_wdata <= SFM_DELAY_MAX) begin
                        next_delay[obj_sub[1:0] - 2'h1] = obj_wdata; // R10
                    end else begin
                        next_err = 1'b1;
                    end
                end
                default: next_err = 1'b1;
            endcase
        end else if (obj_rd) begin
            next_ack   = 1'b1;
            next_rdata = SFM_ZERO16;
            case (obj_index)
                SFM_IDX_UPPER_LIMIT: begin
                    if (obj_sub == SFM_SUB_COUNT) next_rdata = upper_limit;
                    else next_err = 1'b1;
                end
                SFM_IDX_LOWER_LIMIT: begin
                    if (obj_sub == SFM_SUB_COUNT) next_rdata = lower_limit;
                    else next_err = 1'b1;
                end
                SFM_IDX_ENABLES, SFM_IDX_HYSTERESIS, SFM_IDX_DELAY: begin
                    if (obj_sub == SFM_SUB_COUNT) begin
                        next_rdata = SFM_SUB_TOTAL;
                    end else if (!sub_ok) begin
                        next_err = 1'b1;
                    end else if (obj_index == SFM_IDX_ENABLES) begin
                        next_rdata = {15'h0000, enables[obj_sub[1:0] - 2'h1]};
                    end else if (obj_index == SFM_IDX_HYSTERESIS) begin
                        next_rdata = (obj_sub == SFM_SUB_SUPPLY) ? hysteresis : SFM_ZERO16; // R8
                    end else begin
                        next_rdata = delay[obj_sub[1:0] - 2'h1];
                    end
                end
                default: next_err = 1'b1;
            endcase
        end
    end

    // supply compare with hysteresis on release
    always_comb begin
        upper_clear = {1'b0, upper_limit} - {1'b0, hysteresis};
        lower_clear = {1'b0, lower_limit} + {1'b0, hysteresis};
        next_over  = over_fault;
        next_under = under_fault;
        if (supply_meas > upper_limit) begin
            next_over = 1'b1; // R1 R2
        end else if (over_fault && upper_clear[16] == 1'b0
                     && {1'b0, supply_meas} < upper_clear) begin
            next_over = 1'b0; // R6
        end
        if (supply_meas < lower_limit) begin
            next_under = 1'b1; // R11
        end else if (under_fault && {1'b0, supply_meas} > lower_clear) begin
            next_under = 1'b0; // R6
        end
    end

    // configuration and fault registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            upper_limit <= SFM_UPPER_RESET; // R3
            lower_limit <= SFM_LOWER_RESET;
            hysteresis  <= SFM_HYST_RESET; // R7
            enables     <= {SFM_FAULTS{SFM_ENABLE_RESET}}; // R5
            for (int i = 0; i < SFM_FAULTS; i++) begin
                delay[i] <= SFM_DELAY_RESET; // R10
            end
            obj_rdata   <= 16'h0000;
            obj_ack     <= 1'b0;
            obj_err     <= 1'b0;
            over_fault  <= 1'b0;
            under_fault <= 1'b0;
            tick_cnt    <= 32'h00000000;
        end else begin
            upper_limit <= next_upper_limit;
            lower_limit <= next_lower_limit;
            hysteresis  <= next_hysteresis;
            enables     <= next_enables;
            delay       <= next_delay;
            obj_rdata   <= next_rdata;
            obj_ack     <= next_ack;
            obj_err     <= next_err;
            over_fault  <= next_over;
            under_fault <= next_under;
            tick_cnt    <= next_tick_cnt;
        end
    end

    // raw conditions; hysteresis plays no part for the last two
    assign cond[SFM_CH_SUPPLY] = over_fault | under_fault;
    assign cond[SFM_CH_OUTPUT] = output_fault_in; // R8
    assign cond[SFM_CH_RPDO]   = rpdo_timeout_in;

    // one reaction delay qualifier per fault
    generate
        for (genvar g = 0; g < SFM_FAULTS; g++) begin : g_fault
            sfm_fault_timer u_timer (
                .clk        (clk),
                .sys_rst    (sys_rst),
                .tick       (tick),
                .cond       (cond[g]),
                .delay_ms   (delay[g]),
                .active     (act[g]),
                .recognised (recog[g])
            );
        end
    endgenerate

    assign fault_active = act;
    assign emcy_entry   = recog & enables; // R4
endmodule
